//--- src/atfsc_map.svh
`ifndef ATFSC_MAP_SVH
`define ATFSC_MAP_SVH
`define ATFSC_OFF_DRIVE_HEAD 3'h6
`define ATFSC_OFF_STATUS 3'h7
`define ATFSC_OFF_ALT_STATUS 3'h6
`define ATFSC_DH_RESET 8'hA0
`define ATFSC_DH_FIXED_MASK 8'hA0
`define ATFSC_DH_LBA_BIT 6
`define ATFSC_DH_DRV_BIT 4
`define ATFSC_ST_BSY 7
`define ATFSC_ST_DRIVE_READY_FLAG 6
`define ATFSC_ST_DWF 5
`define ATFSC_ST_DSC 4
`define ATFSC_ST_DRQ 3
`define ATFSC_ST_CORRECTED_FLAG 2
`define ATFSC_ST_IDX 1
`define ATFSC_ST_ERR 0
`define ATFSC_IO_INDEX_MIN 6'h01
`define ATFSC_IO_INDEX_MAX 6'h03
`define ATFSC_PRM_FR 6
`define ATFSC_CMD_WR_MULT_NE 8'hCD
`endif

//--- src/atfsc_pkg.sv
package atfsc_pkg;
    typedef enum logic [5:0] {
        ATFSC_CLS_READ = 6'h01,
        ATFSC_CLS_WRITE = 6'h02,
        ATFSC_CLS_SEEK = 6'h04,
        ATFSC_CLS_POWER = 6'h08,
        ATFSC_CLS_MISC = 6'h10,
        ATFSC_CLS_BAD = 6'h20
    } atfsc_cls_e;
    typedef logic [6:0] atfsc_prm_t;
endpackage

//--- src/atfsc_cmd_decode.sv
module atfsc_cmd_decode (
    input wire logic [7:0] code_in,
    output atfsc_pkg::atfsc_cls_e cls_out,
    output atfsc_pkg::atfsc_prm_t param_used_out,
    output logic supported_out
);
    // Parameter mask order: FR SC SN CY DR HD LBA
    always_comb begin
        cls_out = atfsc_pkg::ATFSC_CLS_MISC;
        param_used_out = 7'h04;
        supported_out = 1'b1;
        casez (code_in)
            8'h30, 8'h31, 8'h38, 8'hC5, 8'hCD, 8'h3C, 8'hC0: begin
                cls_out = atfsc_pkg::ATFSC_CLS_WRITE;
                param_used_out = 7'h3F;
            end
            8'h32, 8'h33: begin
                cls_out = atfsc_pkg::ATFSC_CLS_WRITE;
                param_used_out = 7'h1F;
            end
            8'h50: begin
                cls_out = atfsc_pkg::ATFSC_CLS_WRITE;
                param_used_out = 7'h2F;
            end
            8'h20, 8'h21, 8'h40, 8'h41, 8'hC4: begin
                cls_out = atfsc_pkg::ATFSC_CLS_READ;
                param_used_out = 7'h3F;
            end
            8'h22, 8'h23: begin
                cls_out = atfsc_pkg::ATFSC_CLS_READ;
                param_used_out = 7'h1F;
            end
            8'h87: param_used_out = 7'h3F;
            8'h90, 8'hEC, 8'hE4, 8'hE8, 8'h03: param_used_out = 7'h04;
            8'h91: param_used_out = 7'h26;
            8'hC6: param_used_out = 7'h24;
            8'hEF: param_used_out = 7'h44;
            8'hF5: param_used_out = 7'h06;
            8'h1?: param_used_out = 7'h04;
            8'h7?: begin
                cls_out = atfsc_pkg::ATFSC_CLS_SEEK;
                param_used_out = 7'h1F;
            end
            8'hE3, 8'h97: begin
                cls_out = atfsc_pkg::ATFSC_CLS_POWER;
                param_used_out = 7'h24;
            end
            8'hE5, 8'h98, 8'hE1, 8'h95, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'hE6, 8'h99: begin
                cls_out = atfsc_pkg::ATFSC_CLS_POWER;
            end
            default: begin
                cls_out = atfsc_pkg::ATFSC_CLS_BAD;
                param_used_out = 7'h00;
                supported_out = 1'b0;
            end
        endcase
    end
endmodule

//--- src/atfsc_status.sv
`include "atfsc_map.svh"
module atfsc_status (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic busy_in,
    input wire logic drive_ready_in,
    input wire logic write_fault_in,
    input wire logic seek_complete_in,
    input wire logic new_cmd_in,
    input wire logic drq_set_in,
    input wire logic drq_done_in,
    input wire logic corrected_flag_set_in,
    input wire logic err_set_in,
    output logic [7:0] status_out
);
    logic drq_q;
    logic corrected_flag_q;
    logic err_q;
    // Set terms win over clears so no event is lost
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            drq_q <= 1'b0;
            corrected_flag_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            drq_q <= drq_set_in | (drq_q & ~new_cmd_in & ~drq_done_in);
            corrected_flag_q <= corrected_flag_set_in | (corrected_flag_q & ~new_cmd_in);
            err_q <= err_set_in | (err_q & ~new_cmd_in);
        end
    end
    always_comb begin
        status_out = 8'h00;
        status_out[`ATFSC_ST_BSY] = busy_in;
        status_out[`ATFSC_ST_DRIVE_READY_FLAG] = drive_ready_in;
        status_out[`ATFSC_ST_DWF] = write_fault_in;
        status_out[`ATFSC_ST_DSC] = seek_complete_in;
        status_out[`ATFSC_ST_DRQ] = drq_q;
        status_out[`ATFSC_ST_CORRECTED_FLAG] = corrected_flag_q;
        status_out[`ATFSC_ST_IDX] = 1'b0;
        status_out[`ATFSC_ST_ERR] = err_q;
    end
endmodule

//--- src/atfsc_top.sv
`include "atfsc_map.svh"
module atfsc_top #(
    parameter int LBA_W = 28
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce1_b_in,
    input wire logic ce2_b_in,
    input wire logic [2:0] addr_in,
    input wire logic iord_b_in,
    input wire logic iowr_b_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_b_out,
    input wire logic [7:0] sector_number_in,
    input wire logic [7:0] cyl_low_in,
    input wire logic [7:0] cyl_high_in,
    input wire logic drive_number_pin_in,
    input wire logic copy_drive_in,
    input wire logic io_mode_in,
    input wire logic [5:0] config_index_in,
    input wire logic level_irq_in,
    input wire logic interrupt_disable_bit_in,
    input wire logic busy_in,
    input wire logic drive_ready_in,
    input wire logic write_fault_in,
    input wire logic seek_complete_in,
    input wire logic drq_set_in,
    input wire logic drq_done_in,
    input wire logic corrected_flag_set_in,
    input wire logic err_set_in,
    input wire logic irq_event_in,
    output logic interrupt_request_n_out,
    output logic cmd_start_out,
    output logic cmd_abort_out,
    output logic [7:0] cmd_code_out,
    output atfsc_pkg::atfsc_cls_e cmd_class_out,
    output atfsc_pkg::atfsc_prm_t param_used_out,
    output logic lba_mode_out,
    output logic [LBA_W-1:0] lba_out,
    output logic [3:0] head_select_bits_out,
    output logic drive_select_bit_out,
    output logic card_selected_out
);
    generate
        if (LBA_W != 28) begin : g_bad_width
            $error("atfsc_top: LBA_W must be 28");
        end
    endgenerate

    logic rd_act_q;
    logic wr_act_q;
    logic [7:0] dh_q;
    logic [7:0] dh_d;
    logic cmd_pend_q;
    logic irq_pend_q;
    logic irq_pend_d;
    logic irq_n_q;
    logic cmd_start_q;
    logic cmd_abort_q;
    logic [7:0] cmd_code_q;
    atfsc_pkg::atfsc_cls_e cmd_class_q;
    atfsc_pkg::atfsc_prm_t param_used_q;
    logic [7:0] data_q;
    logic oe_b_q;
    logic [LBA_W-1:0] lba_q;

    // Strobe edges; inputs are already synchronous
    wire rd_act = ~iord_b_in;
    wire wr_act = ~iowr_b_in;
    wire rd_edge = rd_act & ~rd_act_q;
    wire wr_edge = wr_act & ~wr_act_q;

    // Address decode: task-file window and control window
    wire tf_win = ~ce1_b_in & ce2_b_in;
    wire ctl_win = ce1_b_in & ~ce2_b_in;
    wire hit_dh = tf_win & (addr_in == `ATFSC_OFF_DRIVE_HEAD);
    wire hit_st = tf_win & (addr_in == `ATFSC_OFF_STATUS);
    wire hit_alt = ctl_win & (addr_in == `ATFSC_OFF_ALT_STATUS);
    wire hit_any = hit_dh | hit_st | hit_alt;

    // card number from socket pin and copy bit
    wire own_card = drive_number_pin_in ^ copy_drive_in;
    wire card_sel = (dh_q[`ATFSC_DH_DRV_BIT] == own_card);

    assign dh_d = data_in | `ATFSC_DH_FIXED_MASK;
    wire dh_wr = wr_edge & hit_dh;

    // Decoder
    atfsc_pkg::atfsc_cls_e dec_cls;
    atfsc_pkg::atfsc_prm_t dec_prm;
    logic dec_ok;
    atfsc_cmd_decode u_decode (
        .code_in(data_in),
        .cls_out(dec_cls),
        .param_used_out(dec_prm),
        .supported_out(dec_ok)
    );

    // busy also covers the gap before the back end answers
    wire busy_now = busy_in | cmd_pend_q;
    // Command writes during busy are dropped; host must wait for busy to clear
    wire cmd_wr = wr_edge & hit_st & card_sel & ~busy_now;

    // media requests need ready and seek complete
    wire needs_ready = (dec_cls == atfsc_pkg::ATFSC_CLS_READ) | (dec_cls == atfsc_pkg::ATFSC_CLS_WRITE)
        | (dec_cls == atfsc_pkg::ATFSC_CLS_SEEK);
    wire ready_ok = drive_ready_in & seek_complete_in;
    wire cmd_go = cmd_wr & dec_ok & (~needs_ready | ready_ok);
    wire cmd_refuse = cmd_wr & ~(dec_ok & (~needs_ready | ready_ok));

    // Status flags
    logic [7:0] status_byte;
    atfsc_status u_status (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .busy_in(busy_now),
        .drive_ready_in(drive_ready_in),
        .write_fault_in(write_fault_in),
        .seek_complete_in(seek_complete_in),
        .new_cmd_in(cmd_wr),
        .drq_set_in(drq_set_in),
        .drq_done_in(drq_done_in),
        .corrected_flag_set_in(corrected_flag_set_in),
        .err_set_in(err_set_in | cmd_refuse),
        .status_out(status_byte)
    );

    // status read clears request only in I/O index 1-3 level mode
    wire io_cfg = io_mode_in & level_irq_in & (config_index_in >= `ATFSC_IO_INDEX_MIN)
        & (config_index_in <= `ATFSC_IO_INDEX_MAX);
    wire st_rd = rd_edge & hit_st & card_sel;
    wire irq_clr = st_rd & io_cfg;
    // alternate status read never clears; event wins over clear
    assign irq_pend_d = irq_event_in | (irq_pend_q & ~irq_clr);

    // Read data mux
    wire [7:0] rd_mux = hit_dh ? dh_q : status_byte;
    wire rd_drive = rd_act & hit_any & card_sel;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            dh_q <= `ATFSC_DH_RESET;
            cmd_pend_q <= 1'b0;
            irq_pend_q <= 1'b0;
            irq_n_q <= 1'b1;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (dh_wr) begin
                dh_q <= dh_d;
            end
            cmd_pend_q <= cmd_go | (cmd_pend_q & ~busy_in);
            irq_pend_q <= irq_pend_d;
            irq_n_q <= ~(irq_pend_d & ~interrupt_disable_bit_in);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            cmd_start_q <= 1'b0;
            cmd_abort_q <= 1'b0;
            cmd_code_q <= 8'h00;
            cmd_class_q <= atfsc_pkg::ATFSC_CLS_MISC;
            param_used_q <= 7'h00;
        end else begin
            cmd_start_q <= cmd_go;
            cmd_abort_q <= cmd_refuse;
            if (cmd_wr) begin
                cmd_code_q <= data_in;
                cmd_class_q <= dec_cls;
                param_used_q <= dec_prm;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            data_q <= 8'h00;
            oe_b_q <= 1'b1;
            lba_q <= '0;
        end else begin
            data_q <= rd_drive ? rd_mux : 8'h00;
            oe_b_q <= ~rd_drive;
            lba_q <= {dh_q[3:0], cyl_high_in, cyl_low_in, sector_number_in};
        end
    end

    assign data_out = data_q;
    assign data_oe_b_out = oe_b_q;
    assign interrupt_request_n_out = irq_n_q;
    assign cmd_start_out = cmd_start_q;
    assign cmd_abort_out = cmd_abort_q;
    assign cmd_code_out = cmd_code_q;
    assign cmd_class_out = cmd_class_q;
    assign param_used_out = param_used_q;
    assign lba_mode_out = dh_q[`ATFSC_DH_LBA_BIT];
    assign lba_out = lba_q;
    assign head_select_bits_out = dh_q[3:0];
    assign drive_select_bit_out = dh_q[`ATFSC_DH_DRV_BIT];
    assign card_selected_out = card_sel;

    AST_DH_FIXED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        dh_q[7] && dh_q[5])
        else $error("drive/head fixed bits not one");

    AST_DH_MODE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        dh_wr |=> (lba_mode_out == $past(data_in[6])) && (head_select_bits_out == $past(data_in[3:0])))
        else $error("drive/head write not stored");

    AST_LBA_BUILD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !dh_wr |=> lba_out == {head_select_bits_out, $past(cyl_high_in), $past(cyl_low_in),
        $past(sector_number_in)})
        else $error("block address mis-assembled");

    // status read drops request; a fresh event may raise it again
    AST_IRQ_CLEAR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (irq_clr && !irq_event_in) |=> interrupt_request_n_out ##1
        (interrupt_request_n_out || $past(irq_event_in)))
        else $error("status read did not drop request");

    AST_ALT_KEEP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (rd_edge && hit_alt && irq_pend_q) |=> irq_pend_q)
        else $error("alternate read dropped request");

    // media request refused when not ready
    AST_REFUSE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cmd_wr && needs_ready && !drive_ready_in) |=> cmd_abort_out && !cmd_start_out
        && status_byte[`ATFSC_ST_ERR])
        else $error("media command accepted while not ready");

    AST_BAD_CODE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cmd_wr && !dec_ok) |=> (cmd_abort_out && !cmd_start_out && status_byte[0])
        ##1 !cmd_abort_out)
        else $error("unknown code not aborted");

    AST_DRQ_CLR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cmd_wr && !drq_set_in) |=> !status_byte[`ATFSC_ST_DRQ])
        else $error("data request survived new command");

    AST_ERR_CLR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cmd_go && !err_set_in) |=> !status_byte[`ATFSC_ST_ERR] && cmd_start_out)
        else $error("error not cleared by command");

    AST_IRQ_GATE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        interrupt_disable_bit_in |=> interrupt_request_n_out)
        else $error("request asserted while disabled");

    // feature never used by the no-erase multiple write
    AST_CDH_PARAM: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cmd_start_out && cmd_code_out == `ATFSC_CMD_WR_MULT_NE) |->
        (!param_used_out[`ATFSC_PRM_FR] && param_used_out[5:0] == 6'h3F))
        else $error("wrong parameter mask for CDH");

    AST_BUSY_START: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        cmd_start_out |-> status_byte[`ATFSC_ST_BSY])
        else $error("busy not shown after start");

    AST_IDX_ZERO: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_drive |=> data_out[`ATFSC_ST_IDX] == 1'b0 || $past(hit_dh))
        else $error("index bit read as one");

    // unselected card stays off the bus
    AST_CARD_SEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (rd_act && !card_sel) |=> data_oe_b_out)
        else $error("unselected card drove data");

    AST_ALT_SAME: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (rd_act && hit_alt && card_sel) |=> data_out == $past(status_byte))
        else $error("alternate status differs from status");

    AST_IRQ_SET: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (irq_event_in && !interrupt_disable_bit_in) |=> !interrupt_request_n_out)
        else $error("request not raised after event");

    // fault and seek levels read back
    AST_ST_LEVELS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (rd_act && hit_st && card_sel) |=> data_out[`ATFSC_ST_DWF] == $past(write_fault_in)
        && data_out[`ATFSC_ST_DSC] == $past(seek_complete_in))
        else $error("fault or seek bit misread");

    AST_BUSY_READ: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (rd_act && hit_st && card_sel && busy_now) |=> data_out[`ATFSC_ST_BSY])
        else $error("busy not read back");

    AST_BUSY_DROP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_edge && hit_st && busy_now) |=> !cmd_start_out && !cmd_abort_out)
        else $error("command taken while busy");

    AST_DRQ_SET: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        drq_set_in |=> status_byte[`ATFSC_ST_DRQ])
        else $error("data request not set");

    AST_CORRECTED_FLAG_SET: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        corrected_flag_set_in |=> status_byte[`ATFSC_ST_CORRECTED_FLAG])
        else $error("corrected flag not set");
endmodule

//--- verification/atfsc_host_model.sv
module atfsc_host_model (
    input wire logic mclk_in,
    input wire logic [7:0] rdata_in,
    output logic ce1_b_out,
    output logic ce2_b_out,
    output logic [2:0] addr_out,
    output logic iord_b_out,
    output logic iowr_b_out,
    output logic [7:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {ce1_b_out, ce2_b_out, iord_b_out, iowr_b_out} = 4'hF;
        addr_out = 3'h0;
        wdata_out = 8'h5A;
    end
    task automatic access(input logic tf, input logic wr, input logic [2:0] a, input logic [7:0] wd,
                          output logic [7:0] rd);
        @(negedge mclk_in);
        ce1_b_out = ~tf;
        ce2_b_out = tf;
        addr_out = a;
        wdata_out = wr ? wd : ~wdata_out;
        iowr_b_out = ~wr;
        iord_b_out = wr;
        @(negedge mclk_in);
        rd = rdata_in;
        // Released bus must not keep the last value
        wdata_out = ~wdata_out;
        iowr_b_out = 1'b1;
        iord_b_out = 1'b1;
    endtask
    task automatic issue_cmd(input logic [7:0] code);
        logic [7:0] st;
        st = 8'hFF;
        for (int i = 0; i < 20 && st[7] !== 1'b0; i++) begin
            access(1'b1, 1'b0, 3'h7, 8'h00, st);
        end
        access(1'b1, 1'b1, 3'h7, code, st);
    endtask
endmodule

//--- verification/ata_task_file_status_command_tb.sv
module ata_task_file_status_command_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, rst_b_in, pin, cpy, io_mode, lvl, dis, dr, wf, sc, ok;
    logic [7:0] sn, cl, ch, st, v, rdata, wdata;
    logic [5:0] idx, cls;
    logic [4:0] pul;
    logic [2:0] addr;
    logic ce1_b, ce2_b, iord_b, iowr_b;
    int num_errors = 0, checks_done = 0, cycles = 0, bcnt = 0, e_drq = 0, e_corrected_flag = 0, e_err = 0;
    wire logic busy = (bcnt != 0);

    atfsc_top dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce1_b_in(ce1_b), .ce2_b_in(ce2_b),
        .addr_in(addr), .iord_b_in(iord_b), .iowr_b_in(iowr_b), .data_in(wdata), .data_out(rdata),
        .data_oe_b_out(), .sector_number_in(sn), .cyl_low_in(cl), .cyl_high_in(ch),
        .drive_number_pin_in(pin), .copy_drive_in(cpy), .io_mode_in(io_mode), .config_index_in(idx),
        .level_irq_in(lvl), .interrupt_disable_bit_in(dis), .busy_in(busy), .drive_ready_in(dr),
        .write_fault_in(wf), .seek_complete_in(sc), .drq_set_in(pul[4]), .drq_done_in(pul[3]),
        .corrected_flag_set_in(pul[2]), .err_set_in(pul[1]), .irq_event_in(pul[0]), .interrupt_request_n_out(),
        .cmd_start_out(), .cmd_abort_out(), .cmd_code_out(), .cmd_class_out(), .param_used_out(),
        .lba_mode_out(), .lba_out(), .head_select_bits_out(), .drive_select_bit_out(),
        .card_selected_out());
    atfsc_host_model host_u (.mclk_in(mclk_in), .rdata_in(rdata), .ce1_b_out(ce1_b), .ce2_b_out(ce2_b),
        .addr_out(addr), .iord_b_out(iord_b), .iowr_b_out(iowr_b), .wdata_out(wdata));

    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    // Back end holds busy three cycles per started command
    always @(negedge mclk_in) begin
        if (dut_u.cmd_start_out === 1'b1) bcnt <= 3;
        else if (bcnt != 0) bcnt <= bcnt - 1;
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_val(input logic [27:0] got, input logic [27:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_st(input logic [7:0] got);
        chk_val({20'h0, got}, {20'h0, 1'b0, dr, wf, sc, e_drq[0], e_corrected_flag[0], 1'b0, e_err[0]});
    endtask
    // One-hot class per code; recalibrate is plain housekeeping
    function automatic logic [5:0] exp_cls(input logic [7:0] c);
        if (c inside {8'h20, 8'h21, 8'h22, 8'h23, 8'h40, 8'h41, 8'hC4}) return 6'h01;
        if (c inside {8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3C, 8'hC5, 8'hCD, 8'hC0, 8'h50}) return 6'h02;
        if (c[7:4] == 4'h7) return 6'h04;
        if (c inside {[8'hE0:8'hE3], 8'hE5, 8'hE6, [8'h94:8'h99]}) return 6'h08;
        if (c inside {8'h03, 8'h87, 8'h90, 8'h91, 8'hC6, 8'hE4, 8'hE8, 8'hEC, 8'hEF, 8'hF5}) return 6'h10;
        return (c[7:4] == 4'h1) ? 6'h10 : 6'h20;
    endfunction
    // Used-parameter mask, bit 6 feature down to bit 0 addressing mode
    function automatic logic [6:0] exp_prm(input logic [7:0] c);
        if (c inside {8'h22, 8'h23, 8'h32, 8'h33} || c[7:4] == 4'h7) return 7'h1F;
        if (c inside {8'h20, 8'h21, 8'h30, 8'h31, 8'h38, 8'h3C, 8'h40, 8'h41, 8'h87, 8'hC0, 8'hC4, 8'hC5, 8'hCD})
            return 7'h3F;
        if (c == 8'h50) return 7'h2F;
        if (c == 8'h91) return 7'h26;
        if (c inside {8'hC6, 8'hE3, 8'h97}) return 7'h24;
        if (c == 8'hEF) return 7'h44;
        if (c == 8'hF5) return 7'h06;
        return (exp_cls(c) == 6'h20) ? 7'h00 : 7'h04;
    endfunction
    task automatic cmd(input logic [7:0] c);
        cls = exp_cls(c);
        ok = (cls != 6'h20) && !((cls inside {6'h01, 6'h02, 6'h04}) && !(dr && sc));
        host_u.issue_cmd(c);
        chk_val(dut_u.cmd_start_out, ok);
        chk_val(dut_u.cmd_abort_out, !ok);
        chk_val(dut_u.cmd_class_out, cls);
        chk_val(dut_u.cmd_code_out, c);
        chk_val(dut_u.param_used_out, exp_prm(c));
        if (ok && c == 8'hCD) chk_val(dut_u.param_used_out, 7'h3F);
        e_drq = 0;
        e_corrected_flag = 0;
        e_err = !ok;
        host_u.access(1'b1, 1'b0, 3'h7, 8'h00, st);
        if (ok) chk_val(st[7], 1'b1);
        else chk_st(st);
    endtask

    initial begin
        void'($urandom(32'hA9C24B32));
        rst_b_in = 1'b0;
        {sn, cl, ch, pin, cpy, io_mode, lvl, dis, dr, wf, sc, idx, pul} = '0;
        repeat (6) @(negedge mclk_in);
        rst_b_in = 1'b1;
        chk_val(dut_u.interrupt_request_n_out, 1'b1);
        chk_val({dut_u.cmd_code_out, dut_u.lba_mode_out, dut_u.drive_select_bit_out, dut_u.head_select_bits_out},
            14'h0);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            {sn, cl, ch} = 24'($urandom);
            {pin, cpy} = 2'($urandom);
            host_u.access(1'b1, 1'b1, 3'h6, v, st);
            @(negedge mclk_in);
            chk_val(dut_u.lba_mode_out, v[6]);
            chk_val(dut_u.head_select_bits_out, v[3:0]);
            chk_val({dut_u.drive_select_bit_out, dut_u.card_selected_out}, {v[4], v[4] == (pin ^ cpy)});
            chk_val(dut_u.lba_out, {v[3:0], ch, cl, sn});
            // Unselected card reads back nothing
            host_u.access(1'b1, 1'b0, 3'h6, 8'h00, st);
            chk_val(st, (v[4] == (pin ^ cpy)) ? (v | 8'hA0) : 8'h00);
        end
        host_u.access(1'b1, 1'b1, 3'h6, {3'b111, pin ^ cpy, 4'h5}, st);
        // Unmapped place must leave the bus alone
        host_u.access(1'b1, 1'b0, 3'h0, 8'h00, st);
        chk_val(dut_u.data_oe_b_out, 1'b1);
        for (int i = 0; i < 12; i++) begin
            {dr, wf, sc} = 3'($urandom);
            v = 8'($urandom) & 8'h1E;
            pul = v[4:0];
            @(negedge mclk_in);
            pul = 5'h00;
            if (v[4]) e_drq = 1;
            else if (v[3]) e_drq = 0;
            if (v[2]) e_corrected_flag = 1;
            if (v[1]) e_err = 1;
            host_u.access(1'b1, 1'b0, 3'h7, 8'h00, st);
            chk_st(st);
            chk_val(dut_u.data_oe_b_out, 1'b0);
        end
        io_mode = 1'b1;
        lvl = 1'b1;
        idx = 6'($urandom_range(3, 1));
        for (int i = 0; i < 3; i++) begin
            dis = (i == 1);
            // Last pass leaves level mode, so the read must not clear
            lvl = (i != 2);
            pul = 5'h01;
            @(negedge mclk_in);
            pul = 5'h00;
            @(negedge mclk_in);
            chk_val(dut_u.interrupt_request_n_out, dis);
            dis = 1'b0;
            @(negedge mclk_in);
            @(negedge mclk_in);
            host_u.access(1'b0, 1'b0, 3'h6, 8'h00, st);
            chk_st(st);
            @(negedge mclk_in);
            chk_val(dut_u.interrupt_request_n_out, 1'b0);
            host_u.access(1'b1, 1'b0, 3'h7, 8'h00, st);
            @(negedge mclk_in);
            chk_val(dut_u.interrupt_request_n_out, i != 2);
        end
        io_mode = 1'b0;
        // Every code with dr/sc at 11, 01 and 10 (both low is not tried)
        for (int p = 0; p < 3; p++) begin
            {dr, sc} = (p == 0) ? 2'b11 : (p == 1) ? 2'b01 : 2'b10;
            for (int c = 0; c < 256; c++) cmd(8'(c));
        end
        {dr, sc} = 2'b11;
        cmd(8'hE0);
        // Second write lands while the back end is still busy
        host_u.issue_cmd(8'hE1);
        host_u.access(1'b1, 1'b1, 3'h7, 8'hE5, st);
        chk_val({dut_u.cmd_start_out, dut_u.cmd_abort_out, dut_u.cmd_code_out}, {2'b00, 8'hE1});
        repeat (4) @(negedge mclk_in);
        host_u.access(1'b1, 1'b0, 3'h7, 8'h00, st);
        chk_st(st);
        host_u.access(1'b1, 1'b1, 3'h6, {3'b101, ~(pin ^ cpy), 4'h0}, st);
        host_u.access(1'b1, 1'b1, 3'h7, 8'h90, st);
        chk_val({dut_u.cmd_start_out, dut_u.cmd_abort_out}, 2'b00);
        print_verdict();
    end
endmodule
